// ===== hw/rxbpi_backplane_end.sv
`timescale 1ns/1ps
module rxbpi_backplane_end
  import rxbpi_pkg::*;
(
  // Backplane link
  rxbpi_link_if.backplane link,
  // System clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp
);

  // System domain state
  logic [7:0]  ctrl;
  logic        busy;
  logic        reqTog;
  logic        ackS1, ackS2, ackSeen;
  logic        rbS1, rbS2, rbSeen;
  logic        rxS1, rxS2, rxSeen;
  logic [7:0]  rbWord;
  logic [15:0] rxWord;
  logic        wrPend;
  logic [31:0] wrAddr;
  // Link domain state
  logic        reqS1, reqS2, reqSeen;
  logic        ackTog;
  logic        cfgWr;
  logic [7:0]  cfgData;
  logic [7:0]  cfgLink;
  logic [9:0]  hpos;
  logic        pulsePrev;
  logic        pulseOut, pulseOe;
  logic [7:0]  sh0, sh4;
  logic [15:0] rxHold;
  logic        rxTog;
  logic [7:0]  rbHold;
  logic        rbTog;

  // Bus decode
  wire addrPhase;
  wire doWrite;
  wire wrCtrl;
  assign addrPhase = hsel & hready & (htrans == HTRANS_NSEQ);
  assign doWrite   = wrPend & (wrAddr == ADDR_CTRL) & ~busy;
  assign wrCtrl    = doWrite;

  // Read data selection
  wire [31:0] rdSel;
  assign rdSel = (haddr == ADDR_CTRL)   ? {24'h0, ctrl} :
                 (haddr == ADDR_STATUS) ? {23'h0, busy, rbWord} :
                 (haddr == ADDR_RXBYTE) ? {16'h0, rxWord} : 32'h0;

  // Bus slave, no wait states
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPend    <= 1'b0;
      wrAddr    <= 32'h0;
      hrdata    <= 32'h0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      wrPend <= addrPhase & hwrite;
      wrAddr <= haddr;
      if (addrPhase && !hwrite) begin
        hrdata <= rdSel;
      end
    end
  end

  // Control word and write request toggle
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl   <= CFG_RESET;
      reqTog <= 1'b0;
      busy   <= 1'b0;
    end else if (wrCtrl) begin
      ctrl   <= hwdata[7:0];
      reqTog <= ~reqTog;
      busy   <= 1'b1;
    end else if (ackS2 != ackSeen) begin
      busy   <= 1'b0;
    end
  end

  // Crossings into the system domain
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      {ackS1, ackS2, ackSeen} <= 3'h0;
      {rbS1, rbS2, rbSeen}    <= 3'h0;
      {rxS1, rxS2, rxSeen}    <= 3'h0;
      rbWord                  <= CFG_RESET;
      rxWord                  <= 16'h0;
    end else begin
      ackS1   <= ackTog;
      ackS2   <= ackS1;
      ackSeen <= ackS2;
      rbS1    <= rbTog;
      rbS2    <= rbS1;
      rbSeen  <= rbS2;
      rxS1    <= rxTog;
      rxS2    <= rxS1;
      rxSeen  <= rxS2;
      if (rbS2 != rbSeen) begin
        rbWord <= rbHold;
      end
      if (rxS2 != rxSeen) begin
        rxWord <= rxHold;
      end
    end
  end

  // Link side mode view
  rxbpi_mode_t mode;
  wire         base;
  wire         rsvd;
  wire         rise;
  wire [9:0]   effPos;
  wire [9:0]   next_hpos;
  assign mode      = rxbpi_decode(cfgLink);
  assign base      = (mode == MODE_BASE);
  assign rsvd      = (mode == MODE_RSVD);
  assign rise      = base & link.rx_frame_pulse & ~pulsePrev;
  assign effPos    = rise ? POS_ZERO : hpos;
  assign next_hpos = (rsvd || effPos == rxbpi_last(mode)) ? POS_ZERO : effPos + POS_ONE;

  // Configuration transfer to the framer
  always_ff @(posedge link.rx_backplane_clock or negedge rst_n) begin
    if (!rst_n) begin
      {reqS1, reqS2, reqSeen} <= 3'h0;
      ackTog  <= 1'b0;
      cfgWr   <= 1'b0;
      cfgData <= CFG_RESET;
      cfgLink <= CFG_RESET;
    end else begin
      reqS1   <= reqTog;
      reqS2   <= reqS1;
      reqSeen <= reqS2;
      cfgWr   <= (reqS2 != reqSeen);
      if (reqS2 != reqSeen) begin
        cfgData <= ctrl;
        cfgLink <= ctrl;
        ackTog  <= ~ackTog;
      end
    end
  end

  // Frame timing and pulse generation outside base rate
  always_ff @(posedge link.rx_backplane_clock or negedge rst_n) begin
    if (!rst_n) begin
      hpos      <= POS_ZERO;
      pulsePrev <= 1'b0;
      pulseOut  <= 1'b0;
      pulseOe   <= 1'b0;
    end else begin
      hpos      <= next_hpos;
      pulsePrev <= link.rx_frame_pulse;
      pulseOut  <= rxbpi_pulse(mode, next_hpos);
      pulseOe   <= ~base & ~rsvd;
    end
  end

  // Capture of the first byte of each frame on both streams
  always_ff @(posedge link.rx_backplane_clock or negedge rst_n) begin
    if (!rst_n) begin
      sh0    <= 8'h0;
      sh4    <= 8'h0;
      rxHold <= 16'h0;
      rxTog  <= 1'b0;
      rbHold <= CFG_RESET;
      rbTog  <= 1'b0;
    end else begin
      sh0    <= {sh0[6:0], link.rx_serial_output0};
      sh4    <= {sh4[6:0], link.rx_serial_output4};
      rbHold <= link.cfgRead;
      if (rbHold != link.cfgRead) begin
        rbTog <= ~rbTog;
      end
      if (!rsvd && effPos == {7'h0, BYTE_LAST}) begin
        rxHold <= {sh4[6:0], link.rx_serial_output4, sh0[6:0], link.rx_serial_output0};
        rxTog  <= ~rxTog;
      end
    end
  end

  // Link outputs
  assign link.cfgWr        = cfgWr;
  assign link.cfgData      = cfgData;
  assign link.hostPulseOut = pulseOut;
  assign link.hostPulseOe  = pulseOe;

endmodule : rxbpi_backplane_end

// ===== hw/rxbpi_framer_end.sv
`timescale 1ns/1ps
module rxbpi_framer_end
  import rxbpi_pkg::*;
(
  // Backplane link
  rxbpi_link_if.framer link,
  // Reset
  input  wire logic         rst_n,
  // Line-side bytes, channel n in lineData[n]
  input  wire rxbpi_bytes_t lineData,
  // Line-side fetch handshake
  output logic [4:0]        slotNext,
  output logic              slotTake,
  // Active configuration
  output logic [7:0]        cfgActive
);

  logic [7:0]   cfg;
  logic [9:0]   pos;
  logic         pulsePrev;
  rxbpi_bytes_t hold;
  logic         ser0Rise;
  logic         ser4Rise;
  logic         ser0Fall;
  logic         ser4Fall;
  logic         pulseOut;
  logic         pulseOe;

  // Pick one bit, MSB first, from a channel byte
  function automatic logic pick_bit(input rxbpi_bytes_t b, input logic [2:0] ch,
                                    input logic [2:0] idx);
    logic [7:0] byteSel;
    byteSel = b[ch];
    return byteSel[BYTE_LAST - idx];
  endfunction : pick_bit

  // Mode decode of the control register
  rxbpi_mode_t mode;
  wire         muxOn;
  wire         baseRate;
  wire         idle;
  wire         edgeInv;
  assign mode     = rxbpi_decode(cfg);
  assign muxOn    = cfg[BIT_MUX];
  assign baseRate = (mode == MODE_BASE);
  assign idle     = (mode == MODE_RSVD);
  assign edgeInv  = cfg[BIT_EDGE] & baseRate;

  // Frame alignment to the far side pulse outside base rate
  wire       pulseRise;
  wire [9:0] effPos;
  wire [9:0] lastPos;
  wire [9:0] next_pos;
  assign pulseRise = link.rx_frame_pulse & ~pulsePrev & ~baseRate & ~idle;
  assign effPos    = pulseRise ? rxbpi_rise_pos(mode) : pos;
  assign lastPos   = rxbpi_last(mode);
  assign next_pos  = (idle || effPos == lastPos) ? POS_ZERO : effPos + POS_ONE;

  // Slot boundaries: a byte per 8 bits, four bytes per slot when multiplexed
  wire          slotEnd;
  wire [4:0]    slotOfNext;
  wire [2:0]    chLow;
  wire [2:0]    chHigh;
  wire [2:0]    bitIdx;
  rxbpi_bytes_t next_hold;
  assign slotEnd    = muxOn ? (effPos[4:0] == SLOT_LAST) : (effPos[2:0] == BYTE_LAST);
  assign slotOfNext = muxOn ? next_pos[9:5] : next_pos[7:3];
  assign chLow      = muxOn ? {1'b0, next_pos[4:3]} : 3'h0;
  assign chHigh     = muxOn ? {1'b1, next_pos[4:3]} : 3'h4;
  assign bitIdx     = next_pos[2:0];
  assign next_hold  = slotEnd ? lineData : hold;

  // Serial bits for the next position, held high when idle
  wire next_ser0;
  wire next_ser4;
  assign next_ser0 = idle ? 1'b1 : pick_bit(next_hold, chLow, bitIdx);
  assign next_ser4 = idle ? 1'b1 : pick_bit(next_hold, chHigh, bitIdx);

  // Control register, written over the link
  always_ff @(posedge link.rx_backplane_clock or negedge rst_n) begin
    if (!rst_n) begin
      cfg <= CFG_RESET;
    end else if (link.cfgWr) begin
      cfg <= link.cfgData & CFG_MASK;
    end
  end

  // Frame position and pulse history
  always_ff @(posedge link.rx_backplane_clock or negedge rst_n) begin
    if (!rst_n) begin
      pos       <= POS_ZERO;
      pulsePrev <= 1'b0;
    end else begin
      pos       <= next_pos;
      pulsePrev <= link.rx_frame_pulse;
    end
  end

  // Byte store and rising-edge serial bits
  always_ff @(posedge link.rx_backplane_clock or negedge rst_n) begin
    if (!rst_n) begin
      hold     <= '0;
      ser0Rise <= 1'b1;
      ser4Rise <= 1'b1;
    end else begin
      hold     <= next_hold;
      ser0Rise <= next_ser0;
      ser4Rise <= next_ser4;
    end
  end

  // Half-cycle delayed copies for falling-edge transitions
  always_ff @(negedge link.rx_backplane_clock or negedge rst_n) begin
    if (!rst_n) begin
      ser0Fall <= 1'b1;
      ser4Fall <= 1'b1;
    end else begin
      ser0Fall <= ser0Rise;
      ser4Fall <= ser4Rise;
    end
  end

  // Frame pulse driven by this end only at base rate
  always_ff @(posedge link.rx_backplane_clock or negedge rst_n) begin
    if (!rst_n) begin
      pulseOut <= 1'b0;
      pulseOe  <= 1'b0;
    end else begin
      pulseOut <= baseRate & (next_pos == POS_ZERO);
      pulseOe  <= baseRate;
    end
  end

  // Line-side fetch outputs
  always_ff @(posedge link.rx_backplane_clock or negedge rst_n) begin
    if (!rst_n) begin
      slotNext  <= SLOT_ONE;
      slotTake  <= 1'b0;
      cfgActive <= CFG_RESET;
    end else begin
      slotNext  <= slotOfNext + SLOT_ONE;
      slotTake  <= slotEnd & ~idle;
      cfgActive <= cfg;
    end
  end

  // Link outputs
  assign link.cfgRead           = cfg;
  assign link.rx_serial_output0 = edgeInv ? ser0Fall : ser0Rise;
  assign link.rx_serial_output4 = edgeInv ? ser4Fall : ser4Rise;
  assign link.devPulseOut       = pulseOut;
  assign link.devPulseOe        = pulseOe;

endmodule : rxbpi_framer_end

// ===== hw/rxbpi_link_if.sv
`timescale 1ns/1ps
interface rxbpi_link_if (
  // Backplane clock
  input wire logic rx_backplane_clock
);
  logic       cfgWr;
  logic [7:0] cfgData;
  logic [7:0] cfgRead;
  logic       rx_serial_output0;
  logic       rx_serial_output4;
  logic       devPulseOut;
  logic       devPulseOe;
  logic       hostPulseOut;
  logic       hostPulseOe;
  logic       rx_frame_pulse;

  // Frame pulse wire level from both enables
  assign rx_frame_pulse = devPulseOe ? devPulseOut : (hostPulseOe & hostPulseOut);

  modport framer (
    input  rx_backplane_clock, cfgWr, cfgData, rx_frame_pulse,
    output cfgRead, rx_serial_output0, rx_serial_output4, devPulseOut, devPulseOe
  );
  modport backplane (
    input  rx_backplane_clock, cfgRead, rx_serial_output0, rx_serial_output4, rx_frame_pulse,
    output cfgWr, cfgData, hostPulseOut, hostPulseOe
  );
endinterface : rxbpi_link_if

// ===== hw/rxbpi_pkg.sv
package rxbpi_pkg;
  // Control register layout
  localparam int         CFG_W     = 8;
  localparam int         BIT_EDGE  = 3;
  localparam int         BIT_MUX   = 2;
  localparam int         SPD_HI    = 1;
  localparam int         SPD_LO    = 0;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] CFG_MASK  = 8'h0F;

  // Speed codes
  localparam logic [1:0] SPD_00 = 2'h0;
  localparam logic [1:0] SPD_01 = 2'h1;
  localparam logic [1:0] SPD_10 = 2'h2;
  localparam logic [1:0] SPD_11 = 2'h3;

  // Frame geometry in link clock cycles
  localparam int         POS_W      = 10;
  localparam logic [9:0] POS_ZERO   = 10'h000;
  localparam logic [9:0] POS_ONE    = 10'h001;
  localparam logic [9:0] LAST_PLAIN = 10'h0FF;
  localparam logic [9:0] LAST_MUX   = 10'h3FF;
  localparam logic [9:0] OFS_HMVIP  = 10'h3FE;
  localparam logic [9:0] OFS_H100   = 10'h3FF;
  localparam logic [2:0] BYTE_LAST  = 3'h7;
  localparam logic [4:0] SLOT_LAST  = 5'h1F;
  localparam logic [4:0] SLOT_ONE   = 5'h01;

  // Controller register map, byte addresses
  localparam logic [31:0] ADDR_CTRL   = 32'h0000_0000;
  localparam logic [31:0] ADDR_STATUS = 32'h0000_0004;
  localparam logic [31:0] ADDR_RXBYTE = 32'h0000_0008;
  localparam int          STAT_BUSY   = 8;
  localparam logic [1:0]  HTRANS_NSEQ = 2'h2;

  typedef logic [7:0][7:0] rxbpi_bytes_t;

  typedef enum logic [2:0] {
    MODE_BASE  = 3'b000,
    MODE_HS    = 3'b001,
    MODE_MUX1  = 3'b010,
    MODE_HMVIP = 3'b011,
    MODE_H100  = 3'b100,
    MODE_RSVD  = 3'b101
  } rxbpi_mode_t;

  // Speed field decodes by multiplex enable
  function automatic rxbpi_mode_t rxbpi_decode(input logic [7:0] cfg);
    rxbpi_mode_t m;
    m = MODE_RSVD;
    if (!cfg[BIT_MUX]) begin
      m = (cfg[SPD_HI:SPD_LO] == SPD_00) ? MODE_BASE : MODE_HS;
    end else begin
      case (cfg[SPD_HI:SPD_LO])
        SPD_01:  m = MODE_MUX1;
        SPD_10:  m = MODE_HMVIP;
        SPD_11:  m = MODE_H100;
        default: m = MODE_RSVD;
      endcase
    end
    return m;
  endfunction : rxbpi_decode

  // Last bit position of a frame
  function automatic logic [9:0] rxbpi_last(input rxbpi_mode_t m);
    return (m == MODE_MUX1 || m == MODE_HMVIP || m == MODE_H100) ? LAST_MUX : LAST_PLAIN;
  endfunction : rxbpi_last

  // Frame position at the rising edge of the frame pulse
  function automatic logic [9:0] rxbpi_rise_pos(input rxbpi_mode_t m);
    logic [9:0] p;
    p = POS_ZERO;
    if (m == MODE_HMVIP) begin
      p = OFS_HMVIP;
    end else if (m == MODE_H100) begin
      p = OFS_H100;
    end
    return p;
  endfunction : rxbpi_rise_pos

  // Frame pulse level at a given position
  function automatic logic rxbpi_pulse(input rxbpi_mode_t m, input logic [9:0] p);
    logic h;
    h = 1'b0;
    case (m)
      MODE_BASE, MODE_HS, MODE_MUX1: h = (p == POS_ZERO);
      MODE_HMVIP: h = (p >= OFS_HMVIP) || (p <= POS_ONE);
      MODE_H100:  h = (p == OFS_H100) || (p == POS_ZERO);
      default:    h = 1'b0;
    endcase
    return h;
  endfunction : rxbpi_pulse
endpackage : rxbpi_pkg

// ===== test/rxbpi_assertions.sv
`timescale 1ns/1ps
module rxbpi_assertions
  import rxbpi_pkg::*;
(
  // Link clock and reset
  input wire logic       rx_backplane_clock,
  input wire logic       rst_n,
  // Control path
  input wire logic       cfgWr,
  input wire logic [7:0] cfgData,
  input wire logic [7:0] cfgRead,
  // Serial side
  input wire logic       rx_serial_output0,
  input wire logic       rx_serial_output4,
  input wire logic       devPulseOe,
  input wire logic       rx_frame_pulse
);
  default clocking cb @(posedge rx_backplane_clock); endclocking
  default disable iff (!rst_n);

  logic [10:0] age;
  logic [7:0]  prevCfg;

  // Cycles since the framer control last changed
  always_ff @(posedge rx_backplane_clock or negedge rst_n) begin
    if (!rst_n) begin
      age     <= 11'h000;
      prevCfg <= 8'h00;
    end else begin
      prevCfg <= cfgRead;
      age     <= (cfgRead != prevCfg) ? 11'h000 : age + {10'h000, ~&age};
    end
  end

  // Mode decode, settled once a mode has run a full mux frame
  wire logic       mux     = cfgRead[BIT_MUX];
  wire logic [1:0] spd     = cfgRead[SPD_HI:SPD_LO];
  wire logic       base    = !mux && spd == SPD_00;
  wire logic       rsvd    = mux && spd == SPD_00;
  wire logic       settled = age[10] && cfgRead == prevCfg;

  // Pulse shapes of the wide sync modes
  sequence s_wide4;
    rx_frame_pulse [*4] ##1 !rx_frame_pulse;
  endsequence
  sequence s_wide2;
    rx_frame_pulse [*2] ##1 !rx_frame_pulse;
  endsequence

  a_reset_clear: assert property ($rose(rst_n) |-> cfgRead == CFG_RESET)
    else $error("control not clear after reset");
  a_write_lands: assert property (cfgWr |=> cfgRead == ($past(cfgData) & CFG_MASK))
    else $error("control write not taken");
  a_base_owns: assert property (base [*2] |-> devPulseOe)
    else $error("framer not driving pulse at base rate");
  a_far_owns: assert property ((!base && !rsvd) [*2] |-> !devPulseOe)
    else $error("framer drives pulse outside base rate");
  a_single_pulse: assert property (settled && (!mux || spd == SPD_01) &&
    $rose(rx_frame_pulse) |=> !rx_frame_pulse) else $error("pulse longer than one bit");
  a_frame_period: assert property (settled && !mux && $rose(rx_frame_pulse)
    |-> ##256 (rx_frame_pulse || age < 11'h100)) else $error("frame length wrong");
  a_hmvip_span: assert property (settled && mux && spd == SPD_10 &&
    $rose(rx_frame_pulse) |-> s_wide4) else $error("four bit pulse wrong");
  a_h100_span: assert property (settled && mux && spd == SPD_11 &&
    $rose(rx_frame_pulse) |-> s_wide2) else $error("two bit pulse wrong");
  a_rsvd_idle: assert property (settled && rsvd |->
    rx_serial_output0 && rx_serial_output4 && !rx_frame_pulse) else $error("reserved not idle");
endmodule : rxbpi_assertions

// ===== test/rxbpi_tb_top.sv
`timescale 1ns/1ps
module rxbpi_tb_top
  import rxbpi_pkg::*;
;
  logic         sys_clk  = 1'h0;
  logic         linkClk  = 1'h0;
  logic         rst_n    = 1'h0;
  logic         hsel     = 1'h0;
  logic         hwrite   = 1'h0;
  logic [1:0]   htrans   = 2'h0;
  logic [31:0]  haddr    = 32'h0;
  logic [31:0]  hwdata   = 32'h0;
  logic [31:0]  hrdata;
  logic         hreadyout;
  logic         hresp;
  rxbpi_bytes_t lineData = 64'h0;
  logic [4:0]   slotNext;
  logic         slotTake;
  logic [7:0]   cfgActive;
  logic [4:0]   exSlot;
  logic [31:0]  seed     = 32'h0000_003A;
  logic [31:0]  s0, s4;
  logic [31:0]  busQ[$];
  logic [63:0]  frmQ[$];
  logic [3:0]   tab[9]   = '{4'h0, 4'h8, 4'h9, 4'h2, 4'h3, 4'h5, 4'h6, 4'hF, 4'h4};
  logic         dp = 1'h0, capOn = 1'h0, free = 1'h0, inCap = 1'h0, prevP = 1'h0;
  logic         fall = 1'h0, edgeChk = 1'h0, mx = 1'h0, aP, aN;
  int           k, ofs, mismatches = 0, nTests = 0;

  // Clocks and link taps
  always #12.5 sys_clk = ~sys_clk;
  always #15 linkClk = ~linkClk;
  rxbpi_link_if i_rxbpi_link_if (.rx_backplane_clock(linkClk));
  wire logic ser0 = i_rxbpi_link_if.rx_serial_output0;
  wire logic ser4 = i_rxbpi_link_if.rx_serial_output4;
  wire logic pls  = i_rxbpi_link_if.rx_frame_pulse;

  rxbpi_framer_end i_rxbpi_framer_end (.link(i_rxbpi_link_if.framer), .rst_n(rst_n),
    .lineData(lineData), .slotNext(slotNext), .slotTake(slotTake), .cfgActive(cfgActive));
  rxbpi_backplane_end i_rxbpi_backplane_end (.link(i_rxbpi_link_if.backplane),
    .sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp));
  rxbpi_assertions i_rxbpi_assertions (.rx_backplane_clock(linkClk), .rst_n(rst_n),
    .cfgWr(i_rxbpi_link_if.cfgWr), .cfgData(i_rxbpi_link_if.cfgData),
    .cfgRead(i_rxbpi_link_if.cfgRead), .rx_serial_output0(ser0), .rx_serial_output4(ser4),
    .devPulseOe(i_rxbpi_link_if.devPulseOe), .rx_frame_pulse(pls));

  // Xorshift stream
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction : xs

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    nTests++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic stopTest();
    $display("checks %0d, mismatches %0d", nTests, mismatches);
    if (mismatches == 0 && nTests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : stopTest

  // Single AHB-Lite transfer, address phase then data phase
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d,
                     input logic chk, output logic [31:0] r);
    @(posedge sys_clk);
    hsel   <= 1'h1;
    htrans <= HTRANS_NSEQ;
    haddr  <= a;
    hwrite <= w;
    do @(posedge sys_clk); while (hreadyout !== 1'h1);
    hsel   <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    dp     <= chk;
    do @(posedge sys_clk); while (hreadyout !== 1'h1);
    dp <= 1'h0;
    r = hrdata;
  endtask : ahb

  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] r;
    busQ.push_back(e);
    ahb(1'h0, a, 32'h0, 1'h1, r);
  endtask : rd

  // One mode: program, refused rewrite, then frame and register checks
  task automatic runMode(input logic [3:0] c);
    logic [31:0]  r;
    rxbpi_bytes_t b;
    seed = xs(seed);
    b[3:0] = seed;
    seed = xs(seed);
    b[7:4] = seed;
    @(posedge linkClk);
    lineData <= b;
    ofs = (c[2:0] == 3'h6) ? 2 : (c[2:0] == 3'h7) ? 1 : 0;
    fall = (c == 4'h8);
    free = (c == 4'h4);
    mx   = c[2];
    if (free) frmQ.push_back(64'hFFFF_FFFF_FFFF_FFFF);
    else if (c[2]) frmQ.push_back({b[0], b[1], b[2], b[3], b[4], b[5], b[6], b[7]});
    else frmQ.push_back({{4{b[0]}}, {4{b[4]}}});
    ahb(1'h1, ADDR_CTRL, {28'h0, c}, 1'h0, r);
    ahb(1'h1, ADDR_CTRL, {28'h0, ~c}, 1'h0, r);
    r[STAT_BUSY] = 1'h1;
    repeat (50) if (r[STAT_BUSY] !== 1'h0) ahb(1'h0, ADDR_STATUS, 32'h0, 1'h0, r);
    repeat (1100) @(posedge linkClk);
    rd(ADDR_CTRL, {28'h0, c});
    rd(ADDR_STATUS, {28'h0, c});
    check(cfgActive, {4'h0, c});
    @(posedge linkClk);
    capOn   <= 1'h1;
    edgeChk <= 1'h1;
    repeat (1100) begin
      @(posedge linkClk);
      if (!capOn) break;
    end
    edgeChk <= 1'h0;
    check(capOn, 1'h0);
    if (!free) rd(ADDR_RXBYTE, {16'h0, b[4], b[0]});
  endtask : runMode

  // Read results against the oldest note
  always @(posedge sys_clk) begin
    if (dp && hreadyout === 1'h1) begin
      check({hresp, hrdata}, {1'h0, busQ.pop_front()});
    end
  end

  // Frame capture from the aligned bit zero
  always @(posedge linkClk) begin
    if (capOn && !inCap && (free || (pls && !prevP))) begin
      inCap = 1'h1;
      k = -ofs;
    end
    if (inCap) begin
      if (k >= 0) begin
        s0 = {s0[30:0], ser0};
        s4 = {s4[30:0], ser4};
        exSlot = (free || mx) ? SLOT_ONE : SLOT_ONE + 5'(k / 8);
        check({slotTake, slotNext}, {!free && k % (mx ? 32 : 8) == 0, exSlot});
      end
      k++;
      if (k == 32) begin
        check({s0, s4}, frmQ.pop_front());
        inCap = 1'h0;
        capOn = 1'h0;
      end
    end
    prevP = pls;
  end

  // Data launch edge, rising or falling
  always @(posedge linkClk) begin
    #1 aP = ser0;
    if (edgeChk && fall) check(aP, aN);
  end
  always @(negedge linkClk) begin
    #1 aN = ser0;
    if (edgeChk && !fall) check(aN, aP);
  end

  // Main sequence
  initial begin
    logic [31:0] r;
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'h1;
    ahb(1'h1, 32'h10, 32'hFFFF_FFFF, 1'h0, r);
    rd(32'h10, 32'h0);
    rd(ADDR_CTRL, 32'h0);
    rd(ADDR_STATUS, 32'h0);
    foreach (tab[i]) runMode(tab[i]);
    stopTest();
  end

  // Watchdog, nine modes of about 70 us each
  initial begin
    #1_500_000;
    check(1'h1, 1'h0);
    stopTest();
  end
endmodule : rxbpi_tb_top
